// ### core/fbtc_pkg.sv
// shared constants for the fieldbus time capture and io register block
package fbtc_pkg;
   localparam logic [15:0] LATCH_INPUT_ONE_CTRL_OFS = 16'h09a9;
   localparam logic [15:0] LATCH_INPUT_ONE_STAT_OFS = 16'h09af;
   localparam logic [15:0] RISE_TS_OFS = 16'h09c0;
   localparam logic [15:0] FALL_TS_OFS = 16'h09c8;
   localparam logic [15:0] NET_EV_OFS = 16'h09f0;
   localparam logic [15:0] HOST_START_OFS = 16'h09f8;
   localparam logic [15:0] HOST_CHG_OFS = 16'h09fc;
   localparam logic [15:0] PART_ID_OFS = 16'hde00;
   localparam logic [15:0] MAKER_ID_OFS = 16'h0e08;
   localparam logic [15:0] DOUT_OFS = 16'h0f00;
   localparam logic [15:0] GPO_OFS = 16'h0f10;
   localparam logic [15:0] GPI_OFS = 16'h0f18;
   localparam logic [15:0] URAM_OFS = 16'h0f80;
   localparam logic [15:0] DIN_OFS = 16'h1000;
   localparam int URAM_BYTES = 128;
   localparam int TS_COUNT = 5;
   // capture registers seen by the snapshot unit, in this order
   localparam logic [15:0] TS_BASE [TS_COUNT] = '{16'h09c0, 16'h09c8, 16'h09f0,
                                                  16'h09f8, 16'h09fc};
   localparam logic [3:0] TS_LEN [TS_COUNT] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h4};
   localparam int CTRL_RISE_BIT = 0;
   localparam int CTRL_FALL_BIT = 1;
   localparam logic [63:0] TS_RESET = 64'h0000000000000000;
   localparam logic [31:0] EV_RESET = 32'h00000000;
   localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage : fbtc_pkg

// ### core/fbtc_regs.sv
// register bank: latch 1 timestamps, buffer event times, ids, io words, user ram
`timescale 1ns/1ps
module fbtc_regs
#(
   parameter logic [15:0] PRODUCT_CODE = 16'h0123, // arbitrary value
   parameter logic [15:0] SILICON_REV = 16'h0001,
   parameter logic [31:0] MAKER_CODE = 32'h00000abc // arbitrary value
)
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [63:0] system_time,
   input wire logic latch_input_one,
   input wire logic latch_owner_host,
   input wire logic frame_start,
   input wire logic net_buffer_event,
   input wire logic host_buffer_start,
   input wire logic host_buffer_change,
   input wire logic link_pol_strap,
   input wire logic [1:0] tx_shift_strap,
   input wire logic eeprom_size_strap,
   input wire logic [1:0] chip_mode_strap,
   input wire logic eeprom_loaded,
   input wire logic dio_inputs_mode,
   input wire logic [15:0] dio_in,
   input wire logic [15:0] gp_in,
   input wire logic [15:0] net_addr,
   input wire logic net_rd,
   input wire logic net_wr,
   input wire logic [7:0] net_wdata,
   input wire logic [7:0] net_wmask,
   output logic [7:0] net_rdata,
   output logic net_rvalid,
   input wire logic [15:0] host_addr,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   output logic host_rvalid,
   input wire logic pram_fifo_wr,
   input wire logic [7:0] pram_fifo_wdata,
   input wire logic pram_fifo_rd,
   output logic [7:0] pram_fifo_rdata,
   output logic pram_fifo_rvalid,
   output logic [15:0] dio_out,
   output logic [15:0] gp_out
);
   logic latch_meta, latch_sync, latch_prev;
   logic [15:0] gpi_meta, gpi_sync, din_meta, din_sync;
   logic [5:0] strap_meta, strap_sync, strap_byte;
   logic strap_taken;
   logic [1:0] latch_ctrl;
   logic flag_rise, flag_fall;
   logic [63:0] rise_ts, fall_ts;
   logic [31:0] frame_time, net_ev_time, start_time, chg_time;
   logic [15:0] general_input_word;
   logic [7:0] scratch_ram [fbtc_pkg::URAM_BYTES];
   logic [7:0] din_ram [2];
   logic fifo_wptr, fifo_rptr;
   logic [63:0] ts_live [fbtc_pkg::TS_COUNT];
   logic net_snap_hit, host_snap_hit;
   logic [7:0] net_snap_data, host_snap_data;
   logic rise_edge, fall_edge, own_rd, own_wr;
   logic [15:0] own_addr;
   logic [7:0] own_wdata, next_net_rdata, next_host_rdata;
   logic [63:0] part_id, maker_id;

   // pins pass two flops; straps are static but still arrive asynchronously
   always_ff @(posedge ref_clk)
   begin
      latch_meta <= latch_input_one;
      latch_sync <= latch_meta;
      latch_prev <= latch_sync;
      gpi_meta <= gp_in;
      gpi_sync <= gpi_meta;
      din_meta <= dio_in;
      din_sync <= din_meta;
      strap_meta <= {link_pol_strap, tx_shift_strap, eeprom_size_strap, chip_mode_strap};
      strap_sync <= strap_meta;
   end

   // straps caught once after reset release so later pin noise cannot move the id
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         strap_taken <= 1'b0;
         strap_byte <= 6'h00;
      end
      else if (!strap_taken)
      begin
         strap_taken <= 1'b1;
         strap_byte <= strap_sync;
      end
   end

   assign rise_edge = latch_sync & ~latch_prev;
   assign fall_edge = ~latch_sync & latch_prev;
   assign own_rd = latch_owner_host ? host_rd : net_rd;
   assign own_wr = latch_owner_host ? host_wr : net_wr;
   assign own_addr = latch_owner_host ? host_addr : net_addr;
   assign own_wdata = latch_owner_host ? host_wdata : net_wdata;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         latch_ctrl <= 2'h0;
      else if (own_wr && own_addr == fbtc_pkg::LATCH_INPUT_ONE_CTRL_OFS)
         latch_ctrl <= own_wdata[1:0];
   end

   // set wins over a read clear in the same cycle; a zero control bit clears the flag ahead of both
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         flag_rise <= 1'b0;
      else if (!latch_ctrl[fbtc_pkg::CTRL_RISE_BIT])
         flag_rise <= 1'b0;
      else if (rise_edge)
         flag_rise <= 1'b1;
      else if (own_rd && own_addr == fbtc_pkg::RISE_TS_OFS)
         flag_rise <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         flag_fall <= 1'b0;
      else if (!latch_ctrl[fbtc_pkg::CTRL_FALL_BIT])
         flag_fall <= 1'b0;
      else if (fall_edge)
         flag_fall <= 1'b1;
      else if (own_rd && own_addr == fbtc_pkg::FALL_TS_OFS)
         flag_fall <= 1'b0;
   end

   // in single-event mode a pending flag locks the stored time
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         rise_ts <= fbtc_pkg::TS_RESET;
      else if (rise_edge && !(latch_ctrl[fbtc_pkg::CTRL_RISE_BIT] && flag_rise))
         rise_ts <= system_time;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         fall_ts <= fbtc_pkg::TS_RESET;
      else if (fall_edge && !(latch_ctrl[fbtc_pkg::CTRL_FALL_BIT] && flag_fall))
         fall_ts <= system_time;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         frame_time <= fbtc_pkg::EV_RESET;
      else if (frame_start)
         frame_time <= system_time[31:0];
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         net_ev_time <= fbtc_pkg::EV_RESET;
      else if (net_buffer_event)
         net_ev_time <= frame_start ? system_time[31:0] : frame_time;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         start_time <= fbtc_pkg::EV_RESET;
      else if (host_buffer_start)
         start_time <= system_time[31:0];
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         chg_time <= fbtc_pkg::EV_RESET;
      else if (host_buffer_change)
         chg_time <= system_time[31:0];
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         general_input_word <= fbtc_pkg::WORD_RESET;
      else
         general_input_word <= gpi_sync;
   end

   // network side writes bit by bit through its mask; host has no write path
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         dio_out <= fbtc_pkg::WORD_RESET;
      else if (net_wr && net_addr[15:1] == fbtc_pkg::DOUT_OFS[15:1])
      begin
         if (net_addr[0])
            dio_out[15:8] <= (dio_out[15:8] & ~net_wmask) | (net_wdata & net_wmask);
         else
            dio_out[7:0] <= (dio_out[7:0] & ~net_wmask) | (net_wdata & net_wmask);
      end
   end

   // both sides may write; network wins a same-byte collision
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         gp_out <= fbtc_pkg::WORD_RESET;
      else
      begin
         if (host_wr && host_addr[15:1] == fbtc_pkg::GPO_OFS[15:1])
            gp_out[host_addr[0]*8 +: 8] <= host_wdata;
         if (net_wr && net_addr[15:1] == fbtc_pkg::GPO_OFS[15:1])
            gp_out[net_addr[0]*8 +: 8] <= net_wdata;
      end
   end

   // no reset: contents are undefined after power-up
   always_ff @(posedge ref_clk)
   begin
      if (host_wr && host_addr[15:7] == fbtc_pkg::URAM_OFS[15:7])
         scratch_ram[host_addr[6:0]] <= host_wdata;
      if (net_wr && net_addr[15:7] == fbtc_pkg::URAM_OFS[15:7])
         scratch_ram[net_addr[6:0]] <= net_wdata;
   end

   // process ram bytes 0..1; sampled inputs override any bus or fifo write
   always_ff @(posedge ref_clk)
   begin
      if (eeprom_loaded)
      begin
         if (host_wr && host_addr[15:1] == fbtc_pkg::DIN_OFS[15:1])
            din_ram[host_addr[0]] <= host_wdata;
         if (net_wr && net_addr[15:1] == fbtc_pkg::DIN_OFS[15:1])
            din_ram[net_addr[0]] <= net_wdata;
         if (pram_fifo_wr)
            din_ram[fifo_wptr] <= pram_fifo_wdata;
      end
      if (dio_inputs_mode)
      begin
         din_ram[0] <= din_sync[7:0];
         din_ram[1] <= din_sync[15:8];
      end
   end

   // fifo pointers walk the two mapped bytes, lowest first
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         fifo_wptr <= 1'b0;
         fifo_rptr <= 1'b0;
         pram_fifo_rdata <= 8'h00;
         pram_fifo_rvalid <= 1'b0;
      end
      else
      begin
         pram_fifo_rvalid <= pram_fifo_rd;
         if (pram_fifo_wr && eeprom_loaded)
            fifo_wptr <= ~fifo_wptr;
         if (pram_fifo_rd)
         begin
            pram_fifo_rdata <= eeprom_loaded ? din_ram[fifo_rptr] : 8'h00;
            if (eeprom_loaded)
               fifo_rptr <= ~fifo_rptr;
         end
      end
   end

   assign ts_live[0] = rise_ts;
   assign ts_live[1] = fall_ts;
   assign ts_live[2] = {32'h00000000, net_ev_time};
   assign ts_live[3] = {32'h00000000, start_time};
   assign ts_live[4] = {32'h00000000, chg_time};

   fbtc_snap u_net_snap
   (
      .ref_clk(ref_clk),
      .srst(srst),
      .rd(net_rd),
      .addr(net_addr),
      .live(ts_live),
      .hit(net_snap_hit),
      .rdata(net_snap_data)
   );

   fbtc_snap u_host_snap
   (
      .ref_clk(ref_clk),
      .srst(srst),
      .rd(host_rd),
      .addr(host_addr),
      .live(ts_live),
      .hit(host_snap_hit),
      .rdata(host_snap_data)
   );

   assign part_id = {16'h0000, 8'h00, 2'b00, strap_byte, PRODUCT_CODE, SILICON_REV};
   assign maker_id = {32'h00000000, MAKER_CODE};

   // one decoder serves both sides; unmapped bytes read zero
   function automatic logic [7:0] read_byte(input logic [15:0] a, input logic snap_hit,
                                            input logic [7:0] sdata);
      logic [7:0] v;
      v = 8'h00;
      if (snap_hit)
         v = sdata;
      else if (a == fbtc_pkg::LATCH_INPUT_ONE_CTRL_OFS)
         v = {6'h00, latch_ctrl};
      else if (a == fbtc_pkg::LATCH_INPUT_ONE_STAT_OFS)
         v = {5'h00, latch_sync, flag_fall, flag_rise};
      else if (a[15:3] == fbtc_pkg::PART_ID_OFS[15:3])
         v = part_id[a[2:0]*8 +: 8];
      else if (a[15:3] == fbtc_pkg::MAKER_ID_OFS[15:3])
         v = maker_id[a[2:0]*8 +: 8];
      else if (a[15:1] == fbtc_pkg::DOUT_OFS[15:1])
         v = dio_out[a[0]*8 +: 8];
      else if (a[15:1] == fbtc_pkg::GPO_OFS[15:1])
         v = gp_out[a[0]*8 +: 8];
      else if (a[15:1] == fbtc_pkg::GPI_OFS[15:1])
         v = general_input_word[a[0]*8 +: 8];
      else if (a[15:7] == fbtc_pkg::URAM_OFS[15:7])
         v = scratch_ram[a[6:0]];
      else if (a[15:1] == fbtc_pkg::DIN_OFS[15:1] && eeprom_loaded)
         v = din_ram[a[0]];
      return v;
   endfunction : read_byte

   always_comb
   begin
      next_net_rdata = read_byte(net_addr, net_snap_hit, net_snap_data);
      next_host_rdata = read_byte(host_addr, host_snap_hit, host_snap_data);
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         net_rdata <= 8'h00;
         net_rvalid <= 1'b0;
         host_rdata <= 8'h00;
         host_rvalid <= 1'b0;
      end
      else
      begin
         net_rvalid <= net_rd;
         host_rvalid <= host_rd;
         if (net_rd)
            net_rdata <= next_net_rdata;
         if (host_rd)
            host_rdata <= next_host_rdata;
      end
   end
endmodule : fbtc_regs

// ### core/fbtc_snap.sv
// per-side snapshot of the upper timestamp bytes, taken when byte 0 is read
`timescale 1ns/1ps
module fbtc_snap
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic rd,
   input wire logic [15:0] addr,
   input wire logic [63:0] live [fbtc_pkg::TS_COUNT],
   output logic hit,
   output logic [7:0] rdata
);
   logic [63:8] snap [fbtc_pkg::TS_COUNT];
   logic [fbtc_pkg::TS_COUNT-1:0] sel;
   logic [2:0] ofs [fbtc_pkg::TS_COUNT];

   genvar i;
   generate
      for (i = 0; i < fbtc_pkg::TS_COUNT; i = i + 1)
      begin : g_ts
         logic [15:0] diff;
         assign diff = addr - fbtc_pkg::TS_BASE[i];
         assign sel[i] = (addr >= fbtc_pkg::TS_BASE[i]) &&
                         (diff < {12'h000, fbtc_pkg::TS_LEN[i]});
         assign ofs[i] = diff[2:0];
         always_ff @(posedge ref_clk)
         begin
            if (srst)
               snap[i] <= fbtc_pkg::TS_RESET[63:8];
            else if (rd && sel[i] && ofs[i] == 3'h0)
               snap[i] <= live[i][63:8];
         end
      end
   endgenerate

   always_comb
   begin
      hit = |sel;
      rdata = 8'h00;
      for (int k = 0; k < fbtc_pkg::TS_COUNT; k++)
      begin
         if (sel[k])
         begin
            // byte 0 live, upper bytes from the frozen copy
            if (ofs[k] == 3'h0)
               rdata = live[k][7:0];
            else
               rdata = snap[k][ofs[k]*8 +: 8];
         end
      end
   end
endmodule : fbtc_snap

// ### verification/fbtc_far_end.sv
// far-end model: running system time as the network master distributes it
`timescale 1ns/1ps
module fbtc_far_end
#(
   parameter logic [63:0] STEP = 64'h0807060504030201
)
(
   input wire logic ref_clk,
   input wire logic srst,
   output logic [63:0] system_time
);
   // uneven step gives each byte its own value, so a swapped byte lane shows
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         system_time <= 64'h0000000000000000;
      else
         system_time <= system_time + STEP;
   end
endmodule : fbtc_far_end

// ### verification/fbtc_regs_chk.sv
// assertion checker for the fieldbus time capture register bank
`timescale 1ns/1ps
module fbtc_regs_chk
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [15:0] net_addr,
   input wire logic net_rd,
   input wire logic net_wr,
   input wire logic [7:0] net_wdata,
   input wire logic [7:0] net_wmask,
   input wire logic net_rvalid,
   input wire logic [15:0] host_addr,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata,
   input wire logic host_rvalid,
   input wire logic eeprom_loaded,
   input wire logic pram_fifo_rd,
   input wire logic pram_fifo_rvalid,
   input wire logic [15:0] dio_out,
   input wire logic [15:0] gp_out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   a_reset_clears_words: assert property ($fell(srst) |-> {dio_out, gp_out} == 32'h0)
      else $error("output words not zero after reset");
   a_dout_host_ignored: assert property (!net_wr |=> $stable(dio_out))
      else $error("digital output moved without a network write");
   a_dout_bit_write: assert property (net_wr && net_addr == fbtc_pkg::DOUT_OFS |=>
      dio_out[7:0] == ($past(dio_out[7:0]) & ~$past(net_wmask) | $past(net_wdata & net_wmask)))
      else $error("digital output bit write wrong");
   a_gpo_host_write: assert property (host_wr && !net_wr && host_addr == fbtc_pkg::GPO_OFS
      |=> gp_out[7:0] == $past(host_wdata))
      else $error("host write to general output lost");
   a_gpo_net_high: assert property (net_wr && net_addr == fbtc_pkg::GPO_OFS + 16'h0001
      |=> gp_out[15:8] == $past(net_wdata))
      else $error("network write to general output high byte lost");
   a_gpo_hold: assert property (!net_wr && !host_wr |=> $stable(gp_out))
      else $error("general output moved without a write");
   a_pram_locked: assert property (host_rd && !eeprom_loaded && host_addr == fbtc_pkg::DIN_OFS
      |=> host_rvalid && host_rdata == 8'h00)
      else $error("process ram readable while not loaded");
   a_fifo_answer: assert property (pram_fifo_rd |=> pram_fifo_rvalid)
      else $error("fifo read got no answer");
   a_net_read_answer: assert property (net_rd |=> net_rvalid)
      else $error("network read got no answer");
   a_host_valid_cause: assert property (host_rvalid |-> $past(host_rd))
      else $error("host answer without a read");
endmodule : fbtc_regs_chk

bind fbtc_regs fbtc_regs_chk u_chk (.ref_clk, .srst, .net_addr, .net_rd, .net_wr, .net_wdata,
   .net_wmask, .net_rvalid, .host_addr, .host_rd, .host_wr, .host_wdata, .host_rdata,
   .host_rvalid, .eeprom_loaded, .pram_fifo_rd, .pram_fifo_rvalid, .dio_out, .gp_out);

// ### verification/test_fieldbus_time_capture_io_regs.sv
// self-checking bench for the fieldbus time capture register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin num_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module test_fieldbus_time_capture_io_regs;
   typedef struct packed {logic [15:0] a; logic [7:0] e;} fbtc_row_t;
   localparam logic [63:0] STEP = 64'h0807060504030201;
   localparam logic [15:0] RISE = fbtc_pkg::RISE_TS_OFS;
   localparam logic [15:0] STAT = fbtc_pkg::LATCH_INPUT_ONE_STAT_OFS;
   logic ref_clk, srst, lat, owner, loaded, dmode, fwr, frd, n_rd, n_wr, h_rd, h_wr, n_v, h_v, f_v;
   logic [3:0] ev;
   logic [15:0] din, gin, n_a, h_a, dout, gout;
   logic [7:0] n_d, n_m, h_d, fd, n_q, h_q, f_q, q;
   logic [63:0] st, c0, c1, c2, va, vb, vc;
   logic [31:0] e1, e2;
   int num_errors = 0;
   int check_count = 0;
   fbtc_row_t rows [18] = '{'{16'h09c0, 8'h00}, '{16'h09c7, 8'h00}, '{16'h09c8, 8'h00},
      '{16'h09f0, 8'h00}, '{16'h09fb, 8'h00}, '{16'h09fc, 8'h00}, '{16'hde00, 8'h01},
      '{16'hde01, 8'h00}, '{16'hde02, 8'h23}, '{16'hde03, 8'h01}, '{16'hde04, 8'h33},
      '{16'hde07, 8'h00}, '{16'h0e08, 8'hbc}, '{16'h0e09, 8'h0a}, '{16'h0e0c, 8'h00},
      '{16'h0f00, 8'h00}, '{16'h0f11, 8'h00}, '{16'h0a00, 8'h00}};
   fbtc_far_end u_far (.ref_clk(ref_clk), .srst(srst), .system_time(st));
   // straps tied: their byte in the part id is then a fixed 8'h33
   fbtc_regs u_dut (.ref_clk(ref_clk), .srst(srst), .system_time(st), .latch_input_one(lat),
      .latch_owner_host(owner), .frame_start(ev[0]), .net_buffer_event(ev[1]),
      .host_buffer_start(ev[2]), .host_buffer_change(ev[3]), .link_pol_strap(1'b1),
      .tx_shift_strap(2'b10), .eeprom_size_strap(1'b0), .chip_mode_strap(2'b11),
      .eeprom_loaded(loaded), .dio_inputs_mode(dmode), .dio_in(din), .gp_in(gin),
      .net_addr(n_a), .net_rd(n_rd), .net_wr(n_wr), .net_wdata(n_d), .net_wmask(n_m),
      .net_rdata(n_q), .net_rvalid(n_v), .host_addr(h_a), .host_rd(h_rd), .host_wr(h_wr),
      .host_wdata(h_d), .host_rdata(h_q), .host_rvalid(h_v), .pram_fifo_wr(fwr),
      .pram_fifo_wdata(fd), .pram_fifo_rd(frd), .pram_fifo_rdata(f_q),
      .pram_fifo_rvalid(f_v), .dio_out(dout), .gp_out(gout));
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic acc(input bit h, w, input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      if (h)
         {h_a, h_d, h_rd, h_wr} <= {a, d, !w, w};
      else
         {n_a, n_d, n_rd, n_wr} <= {a, d, !w, w};
      @(posedge ref_clk);
      {h_rd, h_wr, n_rd, n_wr} <= 4'h0;
      @(negedge ref_clk);
      q = h ? h_q : n_q;
   endtask : acc
   task automatic rc(input bit h, input logic [15:0] a, input logic [7:0] e);
      acc(h, 1'b0, a, 8'h00);
      `CHK($sformatf("byte %h", a), e, q)
   endtask : rc
   task automatic rdn(input bit h, input logic [15:0] a, input int lo, hi, inout logic [63:0] v);
      for (int i = lo; i < hi; i++)
      begin
         acc(h, 1'b0, a + 16'(i), 8'h00);
         v[8*i +: 8] = q;
      end
   endtask : rdn
   task automatic pls(input logic [3:0] m, output logic [31:0] t);
      @(posedge ref_clk);
      ev <= m;
      @(negedge ref_clk);
      t = st[31:0];
      @(posedge ref_clk);
      ev <= 4'h0;
   endtask : pls
   // pin is synchronised, so allow a few cycles of lag before the stamp
   task automatic set_pin(input logic v, output logic [63:0] c);
      @(posedge ref_clk);
      lat <= v;
      @(negedge ref_clk);
      c = st;
      repeat (8) @(posedge ref_clk);
   endtask : set_pin
   // system time wraps within a few dozen steps, so count whole steps from the mark
   function automatic bit win(input logic [63:0] t, c);
      return (t - c) % STEP == 0 && t - c <= STEP * 6;
   endfunction : win
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      num_errors++;
      give_verdict();
   end
   initial
   begin
      srst = 1'b1;
      {lat, owner, loaded, dmode, fwr, frd, ev, din, gin, fd} = '0;
      {n_a, n_rd, n_wr, n_d, h_a, h_rd, h_wr, h_d} = '0;
      n_m = 8'hff;
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      `CHK("output words", 32'h0, {dout, gout})
      foreach (rows[i])
         for (int h = 0; h < 2; h++)
            rc(h[0], rows[i].a, rows[i].e);
      $display("test reset values done");
      set_pin(1'b1, c0);
      rdn(1'b0, RISE, 0, 1, va);
      set_pin(1'b0, c1);
      set_pin(1'b1, c2);
      rdn(1'b0, RISE, 1, 8, va);
      rdn(1'b1, RISE, 0, 8, vb);
      rdn(1'b0, fbtc_pkg::FALL_TS_OFS, 0, 8, vc);
      `CHK("rise held by snapshot", 1'b1, win(va, c0))
      `CHK("rise other side", 1'b1, win(vb, c2))
      `CHK("fall stamp", 1'b1, win(vc, c1))
      $display("test capture done");
      rc(1'b0, STAT, 8'h04);
      acc(1'b0, 1'b1, fbtc_pkg::LATCH_INPUT_ONE_CTRL_OFS, 8'h03);
      set_pin(1'b0, c0);
      set_pin(1'b1, c0);
      rc(1'b0, STAT, 8'h07);
      acc(1'b1, 1'b0, RISE, 8'h00);
      vc[7:0] = q;
      set_pin(1'b0, c0);
      set_pin(1'b1, c0);
      rc(1'b1, RISE, vc[7:0]);
      rc(1'b0, STAT, 8'h07);
      rc(1'b0, RISE, vc[7:0]);
      rc(1'b0, STAT, 8'h06);
      acc(1'b0, 1'b0, fbtc_pkg::FALL_TS_OFS, 8'h00);
      rc(1'b0, STAT, 8'h04);
      $display("test flags done");
      pls(4'h1, e1);
      pls(4'h2, e2);
      rdn(1'b1, fbtc_pkg::NET_EV_OFS, 0, 4, va);
      `CHK("frame time", e1, va[31:0])
      pls(4'h8, e1);
      rdn(1'b0, fbtc_pkg::HOST_CHG_OFS, 0, 4, va);
      `CHK("change time", e1, va[31:0])
      pls(4'h4, e1);
      rc(1'b0, fbtc_pkg::HOST_START_OFS, e1[7:0]);
      pls(4'h4, e2);
      for (int i = 1; i < 4; i++)
         rc(1'b0, fbtc_pkg::HOST_START_OFS + 16'(i), e1[8*i +: 8]);
      rdn(1'b1, fbtc_pkg::HOST_START_OFS, 0, 4, va);
      `CHK("start time", e2, va[31:0])
      $display("test event times done");
      acc(1'b1, 1'b1, fbtc_pkg::GPO_OFS, 8'h5a);
      acc(1'b0, 1'b1, fbtc_pkg::GPO_OFS + 16'h0001, 8'hc3);
      `CHK("gp_out", 16'hc35a, gout)
      rc(1'b0, fbtc_pkg::GPO_OFS, 8'h5a);
      n_m <= 8'h0f;
      acc(1'b0, 1'b1, fbtc_pkg::DOUT_OFS, 8'hff);
      acc(1'b1, 1'b1, fbtc_pkg::DOUT_OFS + 16'h0001, 8'hff);
      `CHK("dio_out", 16'h000f, dout)
      gin <= 16'hbeef;
      acc(1'b1, 1'b1, fbtc_pkg::GPI_OFS, 8'h00);
      rc(1'b0, fbtc_pkg::GPI_OFS, 8'hef);
      rc(1'b1, fbtc_pkg::GPI_OFS + 16'h0001, 8'hbe);
      acc(1'b0, 1'b1, fbtc_pkg::URAM_OFS, 8'h11);
      acc(1'b1, 1'b1, fbtc_pkg::URAM_OFS + 16'h007f, 8'h22);
      rc(1'b1, fbtc_pkg::URAM_OFS, 8'h11);
      rc(1'b0, fbtc_pkg::URAM_OFS + 16'h007f, 8'h22);
      $display("test io words done");
      acc(1'b0, 1'b1, fbtc_pkg::DIN_OFS, 8'h55);
      rc(1'b1, fbtc_pkg::DIN_OFS, 8'h00);
      loaded <= 1'b1;
      @(posedge ref_clk);
      {fwr, fd} <= 9'h1aa;
      @(posedge ref_clk);
      fd <= 8'hbb;
      @(posedge ref_clk);
      {fwr, frd} <= 2'b01;
      @(posedge ref_clk);
      frd <= 1'b0;
      @(negedge ref_clk);
      `CHK("fifo read", 8'haa, f_q)
      `CHK("fifo valid", 1'b1, f_v)
      rc(1'b0, fbtc_pkg::DIN_OFS + 16'h0001, 8'hbb);
      {dmode, din} <= 17'h11234;
      repeat (5) @(posedge ref_clk);
      rc(1'b0, fbtc_pkg::DIN_OFS, 8'h34);
      rc(1'b1, fbtc_pkg::DIN_OFS + 16'h0001, 8'h12);
      $display("test process ram done");
      give_verdict();
   end
endmodule : test_fieldbus_time_capture_io_regs
